// file: design/bfrc_pkg.sv
// bfrc_pkg: register map, field positions, reset values and codes
// for the bulk FIFO RAM control and status block.
// assumes a 12-bit byte address on a plain 32-bit register port.
package bfrc_pkg;

  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] MISC_OFS     = 12'h0f8;
  localparam logic [ADDR_W-1:0] PTR_OFS      = 12'h0fc;
  localparam logic [ADDR_W-1:0] WIN_OFS      = 12'h100;
  localparam logic [ADDR_W-1:0] DEPTH_OFS    = 12'h104;
  localparam logic [ADDR_W-1:0] OCC_OFS      = 12'h108;
  localparam logic [ADDR_W-1:0] CTRL_OFS     = 12'h200;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 12'h204;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 12'h208;

  // field positions; host bit 00 (msb first numbering) is our bit 31
  localparam int CODE_LSB    = 27;
  localparam int CODE_W      = 4;
  localparam int TXC_LSB     = 16;
  localparam int RXC_LSB     = 0;
  localparam int CELL_W      = 9;
  localparam int PTR_W       = 11;
  localparam int RAM_W       = 33;
  localparam int DEPTH_W     = 10;
  localparam int TXD_LSB     = 16;
  localparam int RXD_LSB     = 0;
  localparam int CNT_W       = 12;
  localparam int TXF_LSB     = 16;
  localparam int RXF_LSB     = 0;
  localparam int ALT_SEL_BIT = 1;
  localparam int CLASS_W     = 3;
  localparam int IRQ_W       = 2;
  localparam int IRQ_BAD     = 0;
  localparam int IRQ_RX      = 1;

  // reset values
  localparam logic [DEPTH_W-1:0] TXD_RST  = 10'h000;
  localparam logic [DEPTH_W-1:0] RXD_RST  = 10'h07d;
  localparam logic [CELL_W-1:0]  CELL_RST = 9'h000;
  localparam logic [CLASS_W-1:0] ALT_CLASS_MAX = 3'h5;

  // bad access codes
  localparam logic [CODE_W-1:0] CODE_NONE       = 4'h0;
  localparam logic [CODE_W-1:0] CODE_ARX_EMPTY  = 4'h1;
  localparam logic [CODE_W-1:0] CODE_ARX_PAUSED = 4'h2;
  localparam logic [CODE_W-1:0] CODE_ATX_FULL   = 4'h3;
  localparam logic [CODE_W-1:0] CODE_IRX_EMPTY  = 4'h4;
  localparam logic [CODE_W-1:0] CODE_IRX_PAUSED = 4'h5;
  localparam logic [CODE_W-1:0] CODE_ITX_FULL   = 4'h6;
  localparam logic [CODE_W-1:0] CODE_MRX_EMPTY  = 4'h7;
  localparam logic [CODE_W-1:0] CODE_MRX_PAUSED = 4'h8;
  localparam logic [CODE_W-1:0] CODE_MRX_EARLY  = 4'h9;
  localparam logic [CODE_W-1:0] CODE_MRX_APP    = 4'ha;
  localparam logic [CODE_W-1:0] CODE_MTX_FULL   = 4'hb;
  localparam logic [CODE_W-1:0] CODE_MTX_APP    = 4'hc;

endpackage : bfrc_pkg

// file: design/bfrc_ram.sv
// bfrc_ram: bulk FIFO word store with one write port and an
// asynchronous read port; words never written since reset read zero.
// assumes the caller registers the read data.
`timescale 1ns/1ps
module bfrc_ram #(
  parameter int AW = 11,
  parameter int DW = 33
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          srst,
  // access
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0]      mem [0:(2**AW)-1];
  logic [(2**AW)-1:0] written_reg;

  // the array has no reset; a per-word flag gives reads of stale words a zero
  always_ff @(posedge clk) begin
    if (srst) begin
      written_reg <= '0;
    end else if (we) begin
      written_reg[addr] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = written_reg[addr] ? mem[addr] : '0;

endmodule : bfrc_ram

// file: design/bfrc_top.sv
// bfrc_top: bulk FIFO RAM control and status registers, bad access
// code capture, RAM window, async FIFO depths and occupancy, interrupt.
// assumes all inputs come from logic on clk, host strobes one cycle.
`timescale 1ns/1ps
module bfrc_top (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         srst,
  // register port
  input  wire logic [bfrc_pkg::ADDR_W-1:0]  addr,
  input  wire logic [bfrc_pkg::DATA_W-1:0]  wr_data,
  input  wire logic                         wr_en,
  input  wire logic                         rd_en,
  output logic      [bfrc_pkg::DATA_W-1:0]  rd_data,
  // host accesses to the async FIFOs
  input  wire logic                         async_rx_host_pop,
  input  wire logic                         async_rx_paused,
  input  wire logic                         async_tx_host_push,
  // link side of the async FIFOs
  input  wire logic                         async_tx_link_pop,
  input  wire logic                         async_rx_link_push,
  // host accesses to the iso FIFOs
  input  wire logic                         iso_rx_pop,
  input  wire logic                         iso_rx_empty,
  input  wire logic                         iso_rx_paused,
  input  wire logic                         iso_tx_push,
  input  wire logic                         iso_tx_full,
  // host accesses to the mpeg FIFOs
  input  wire logic                         mpeg_rx_pop,
  input  wire logic                         mpeg_rx_empty,
  input  wire logic                         mpeg_rx_paused,
  input  wire logic                         mpeg_ts_released,
  input  wire logic                         app_stream_rx_mode,
  input  wire logic                         mpeg_tx_push,
  input  wire logic                         mpeg_tx_full,
  input  wire logic                         app_stream_tx_mode,
  // cell sizing
  input  wire logic [bfrc_pkg::CELL_W-1:0]  std_tx_cell_size,
  input  wire logic [bfrc_pkg::CELL_W-1:0]  std_rx_cell_size,
  input  wire logic [bfrc_pkg::CLASS_W-1:0] tx_class,
  output logic      [bfrc_pkg::CELL_W-1:0]  eff_tx_cell_size,
  output logic      [bfrc_pkg::CELL_W-1:0]  eff_rx_cell_size,
  // async FIFO status
  output logic      [bfrc_pkg::DEPTH_W-1:0] async_tx_depth,
  output logic      [bfrc_pkg::DEPTH_W-1:0] async_rx_depth,
  output logic                              async_tx_full,
  output logic                              async_rx_empty,
  // interrupt
  output logic                              irq
);
  import bfrc_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction : hit

  // depth in quadlets
  function automatic logic [CNT_W-1:0] quad4(input logic [DEPTH_W-1:0] d);
    return {d, 2'b00};
  endfunction : quad4

  logic [CODE_W-1:0]  code_reg;
  logic [CODE_W-1:0]  code_evt;
  logic [CELL_W-1:0]  alt_tx_cell_size_reg;
  logic [CELL_W-1:0]  alt_rx_cell_size_reg;
  logic               alt_cell_select_reg;
  logic [PTR_W-1:0]   ptr_reg;
  logic [RAM_W-1:0]   ram_rdata;
  logic [DEPTH_W-1:0] tx_depth_reg;
  logic [DEPTH_W-1:0] rx_depth_reg;
  logic [CNT_W-1:0]   tx_used_reg, tx_used_next, rx_fill_reg, rx_fill_next;
  logic [CNT_W-1:0]   tx_cap, rx_cap, tx_free;
  logic               tx_full_now, tx_push_ok, tx_pop_ok, rx_push_ok, rx_pop_ok;
  logic [IRQ_W-1:0]   irq_stat_reg;
  logic [IRQ_W-1:0]   irq_stat_next;
  logic [IRQ_W-1:0]   irq_mask_reg;
  logic [IRQ_W-1:0]   irq_mask_next;
  logic [DATA_W-1:0]  rd_mux;
  logic               wr_misc, wr_ptr, wr_win, rd_win, wr_depth;
  logic               wr_ctrl, wr_stat, wr_mask, async_grp, iso_grp;

  assign wr_misc  = wr_en && hit(addr, MISC_OFS);
  assign wr_ptr   = wr_en && hit(addr, PTR_OFS);
  assign wr_win   = wr_en && hit(addr, WIN_OFS);
  assign rd_win   = rd_en && hit(addr, WIN_OFS);
  assign wr_depth = wr_en && hit(addr, DEPTH_OFS);
  assign wr_ctrl  = wr_en && hit(addr, CTRL_OFS);
  assign wr_stat  = wr_en && hit(addr, IRQ_STAT_OFS);
  assign wr_mask  = wr_en && hit(addr, IRQ_MASK_OFS);

  assign async_grp = async_rx_host_pop || async_tx_host_push;
  assign iso_grp   = iso_rx_pop || iso_tx_push;

  // bad access classification; the host makes one access at a time,
  // so the order only matters for a misbehaving source
  always_comb begin
    code_evt = CODE_NONE;
    if (async_rx_host_pop && rx_fill_reg == '0) begin
      code_evt = CODE_ARX_EMPTY;
    end else if (async_rx_host_pop && async_rx_paused) begin
      code_evt = CODE_ARX_PAUSED;
    end else if (async_tx_host_push && tx_full_now) begin
      code_evt = CODE_ATX_FULL;
    end else if (iso_rx_pop && iso_rx_empty) begin
      code_evt = CODE_IRX_EMPTY;
    end else if (iso_rx_pop && iso_rx_paused) begin
      code_evt = CODE_IRX_PAUSED;
    end else if (iso_tx_push && iso_tx_full) begin
      code_evt = CODE_ITX_FULL;
    end else if (mpeg_rx_pop && app_stream_rx_mode) begin
      code_evt = CODE_MRX_APP;
    end else if (mpeg_rx_pop && mpeg_rx_empty) begin
      code_evt = CODE_MRX_EMPTY;
    end else if (mpeg_rx_pop && mpeg_rx_paused) begin
      code_evt = CODE_MRX_PAUSED;
    end else if (mpeg_rx_pop && !mpeg_ts_released) begin
      code_evt = CODE_MRX_EARLY;
    end else if (mpeg_tx_push && app_stream_tx_mode) begin
      code_evt = CODE_MTX_APP;
    end else if (mpeg_tx_push && mpeg_tx_full) begin
      code_evt = CODE_MTX_FULL;
    end
  end

  // no write path: software cannot clear the code
  always_ff @(posedge clk) begin
    if (srst) begin
      code_reg <= CODE_NONE;
    end else if (code_evt != CODE_NONE) begin
      code_reg <= code_evt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      alt_tx_cell_size_reg <= CELL_RST;
      alt_rx_cell_size_reg <= CELL_RST;
    end else if (wr_misc) begin
      alt_tx_cell_size_reg <= wr_data[TXC_LSB +: CELL_W];
      alt_rx_cell_size_reg <= wr_data[RXC_LSB +: CELL_W];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      alt_cell_select_reg <= 1'b0;
    end else if (wr_ctrl) begin
      alt_cell_select_reg <= wr_data[ALT_SEL_BIT];
    end
  end

  // the alternate tx size only reaches classes up to ALT_CLASS_MAX; the alternate rx size follows the select alone
  always_ff @(posedge clk) begin
    if (srst) begin
      eff_tx_cell_size <= CELL_RST;
      eff_rx_cell_size <= CELL_RST;
    end else begin
      if (alt_cell_select_reg && tx_class <= ALT_CLASS_MAX) begin
        eff_tx_cell_size <= alt_tx_cell_size_reg;
      end else begin
        eff_tx_cell_size <= std_tx_cell_size;
      end
      eff_rx_cell_size <= alt_cell_select_reg ? alt_rx_cell_size_reg
                                              : std_rx_cell_size;
    end
  end

  // pointer wraps at the top of the window
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_reg <= '0;
    end else if (wr_ptr) begin
      ptr_reg <= wr_data[PTR_W-1:0];
    end else if (wr_win || rd_win) begin
      ptr_reg <= ptr_reg + 1'b1;
    end
  end

  // 33rd bit is not reachable from the 32-bit window and is written zero
  bfrc_ram #(
    .AW (PTR_W),
    .DW (RAM_W)
  ) u_ram (
    .clk   (clk),
    .srst  (srst),
    .we    (wr_win),
    .addr  (ptr_reg),
    .wdata ({1'b0, wr_data}),
    .rdata (ram_rdata)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_depth_reg <= TXD_RST;
      rx_depth_reg <= RXD_RST;
    end else if (wr_depth) begin
      tx_depth_reg <= wr_data[TXD_LSB +: DEPTH_W];
      rx_depth_reg <= wr_data[RXD_LSB +: DEPTH_W];
    end
  end

  assign async_tx_depth = tx_depth_reg;
  assign async_rx_depth = rx_depth_reg;

  // occupancy tracking; illegal host accesses leave the counts alone
  assign tx_cap      = quad4(tx_depth_reg);
  assign rx_cap      = quad4(rx_depth_reg);
  assign tx_full_now = tx_used_reg >= tx_cap;
  assign tx_push_ok  = async_tx_host_push && !tx_full_now;
  assign tx_pop_ok   = async_tx_link_pop && tx_used_reg != '0;
  assign rx_push_ok  = async_rx_link_push && rx_fill_reg < rx_cap;
  assign rx_pop_ok   = async_rx_host_pop && rx_fill_reg != '0 && !async_rx_paused;
  assign tx_used_next = tx_used_reg + CNT_W'(tx_push_ok) - CNT_W'(tx_pop_ok);
  assign rx_fill_next = rx_fill_reg + CNT_W'(rx_push_ok) - CNT_W'(rx_pop_ok);
  // shrinking the depth below the held data reads as no free room
  assign tx_free = tx_full_now ? '0 : tx_cap - tx_used_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_used_reg <= '0;
      rx_fill_reg <= '0;
    end else begin
      tx_used_reg <= tx_used_next;
      rx_fill_reg <= rx_fill_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      async_tx_full  <= 1'b1;
      async_rx_empty <= 1'b1;
    end else begin
      async_tx_full  <= tx_used_next >= tx_cap;
      async_rx_empty <= rx_fill_next == '0;
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_stat) begin
      irq_stat_next = irq_stat_next & ~wr_data[IRQ_W-1:0];
    end
    irq_stat_next[IRQ_BAD] = irq_stat_next[IRQ_BAD] || code_evt != CODE_NONE;
    irq_stat_next[IRQ_RX]  = irq_stat_next[IRQ_RX] || rx_push_ok;
  end

  assign irq_mask_next = wr_mask ? wr_data[IRQ_W-1:0] : irq_mask_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq          <= |(irq_stat_next & irq_mask_next);
    end
  end

  always_comb begin
    rd_mux = '0;
    if (hit(addr, MISC_OFS)) begin
      rd_mux[CODE_LSB +: CODE_W] = code_reg;
      rd_mux[TXC_LSB +: CELL_W]  = alt_tx_cell_size_reg;
      rd_mux[RXC_LSB +: CELL_W]  = alt_rx_cell_size_reg;
    end else if (hit(addr, PTR_OFS)) begin
      rd_mux[PTR_W-1:0] = ptr_reg;
    end else if (hit(addr, WIN_OFS)) begin
      rd_mux = ram_rdata[DATA_W-1:0];
    end else if (hit(addr, DEPTH_OFS)) begin
      rd_mux[TXD_LSB +: DEPTH_W] = tx_depth_reg;
      rd_mux[RXD_LSB +: DEPTH_W] = rx_depth_reg;
    end else if (hit(addr, OCC_OFS)) begin
      rd_mux[TXF_LSB +: CNT_W] = tx_free;
      rd_mux[RXF_LSB +: CNT_W] = rx_fill_reg;
    end else if (hit(addr, CTRL_OFS)) begin
      rd_mux[ALT_SEL_BIT] = alt_cell_select_reg;
    end else if (hit(addr, IRQ_STAT_OFS)) begin
      rd_mux[IRQ_W-1:0] = irq_stat_reg;
    end else if (hit(addr, IRQ_MASK_OFS)) begin
      rd_mux[IRQ_W-1:0] = irq_mask_reg;
    end
  end

  // data stand for one cycle only, zero otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_en ? rd_mux : '0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_arx_empty;
    async_rx_host_pop && rx_fill_reg == '0 |=> code_reg == CODE_ARX_EMPTY;
  endproperty
  a_arx_empty: assert property (p_arx_empty) else $error("empty pop code wrong");
  property p_itx_full;
    !async_grp && !iso_rx_pop && iso_tx_push && iso_tx_full
      |=> code_reg == CODE_ITX_FULL;
  endproperty
  a_itx_full: assert property (p_itx_full) else $error("iso full code wrong");
  property p_mrx_early;
    !async_grp && !iso_grp && mpeg_rx_pop && !app_stream_rx_mode && !mpeg_rx_empty
      && !mpeg_rx_paused && !mpeg_ts_released |=> code_reg == CODE_MRX_EARLY;
  endproperty
  a_mrx_early: assert property (p_mrx_early) else $error("early pop code wrong");
  property p_mtx_app;
    !async_grp && !iso_grp && !mpeg_rx_pop && mpeg_tx_push && app_stream_tx_mode
      |=> code_reg == CODE_MTX_APP;
  endproperty
  a_mtx_app: assert property (p_mtx_app) else $error("app push code wrong");
  property p_reset_vals;
    $past(srst) |-> code_reg == CODE_NONE && tx_free == '0 && rx_fill_reg == '0
      && rx_depth_reg == RXD_RST && ptr_reg == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");
  // sampled srst: the edge that ends reset still loads the reset value
  property p_code_hold;
    !srst && code_evt == CODE_NONE |=> $stable(code_reg);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("code changed");
  property p_ptr_inc;
    wr_win || rd_win |=> ptr_reg == $past(ptr_reg) + 1'b1;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not stepped");
  property p_rd_idle;
    !rd_en |=> rd_data == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_alt_tx;
    !srst && alt_cell_select_reg && tx_class <= ALT_CLASS_MAX
      |=> eff_tx_cell_size == $past(alt_tx_cell_size_reg);
  endproperty
  a_alt_tx: assert property (p_alt_tx) else $error("alt tx size unused");

endmodule : bfrc_top

// file: tb/bfrc_host.sv
// bfrc_host: host cpu model that drives the plain register port.
// assumes one access at a time, started by the bench after reset.
`timescale 1ns/1ps
module bfrc_host (
  // clock
  input  wire logic                        clk,
  // register port
  output logic      [bfrc_pkg::ADDR_W-1:0] addr,
  output logic      [bfrc_pkg::DATA_W-1:0] wr_data,
  output logic                             wr_en,
  output logic                             rd_en,
  input  wire logic [bfrc_pkg::DATA_W-1:0] rd_data
);
  import bfrc_pkg::*;

  initial begin
    addr    = '0;
    wr_data = '0;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
  end

  // address and data hold until the next access
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask : rd
endmodule : bfrc_host

// file: tb/tb.sv
// tb: self-checking bench for bfrc_top with a host model on the register port.
// assumes a 10 MHz clock and the register map of bfrc_pkg.
`timescale 1ns/1ps
module tb;
  import bfrc_pkg::*;

  logic              clk;
  logic              srst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_en;
  logic              rd_en;
  logic [DATA_W-1:0] rd_data;
  logic [7:0]        stb;
  logic [9:0]        lv;
  logic [CELL_W-1:0] std_tx_cell_size;
  logic [CELL_W-1:0] std_rx_cell_size;
  logic [CLASS_W-1:0] tx_class;
  logic [CELL_W-1:0] eff_tx_cell_size;
  logic [CELL_W-1:0] eff_rx_cell_size;
  logic              irq;
  logic [DEPTH_W-1:0] atd;
  logic [DEPTH_W-1:0] ard;
  logic              atf;
  logic              are;
  logic [CELL_W-1:0] txc;
  logic [CELL_W-1:0] rxc;
  logic [CELL_W-1:0] stx;
  logic [CELL_W-1:0] srx;
  logic [DATA_W-1:0] ram [4];
  int                sidx [4:12] = '{4, 4, 5, 6, 6, 6, 6, 7, 7};
  int                seed;
  int                num_errors = 0;
  int                checked = 0;

  bfrc_top bfrc_top_i (
    .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data),
    .async_tx_host_push(stb[0]), .async_tx_link_pop(stb[1]),
    .async_rx_link_push(stb[2]), .async_rx_host_pop(stb[3]), .async_rx_paused(lv[0]),
    .iso_rx_pop(stb[4]), .iso_tx_push(stb[5]), .iso_rx_empty(lv[1]),
    .iso_rx_paused(lv[2]), .iso_tx_full(lv[3]),
    .mpeg_rx_pop(stb[6]), .mpeg_tx_push(stb[7]), .mpeg_rx_empty(lv[4]),
    .mpeg_rx_paused(lv[5]), .mpeg_ts_released(~lv[6]), .app_stream_rx_mode(lv[7]),
    .mpeg_tx_full(lv[8]), .app_stream_tx_mode(lv[9]),
    .std_tx_cell_size(std_tx_cell_size), .std_rx_cell_size(std_rx_cell_size),
    .tx_class(tx_class), .eff_tx_cell_size(eff_tx_cell_size),
    .eff_rx_cell_size(eff_rx_cell_size), .async_tx_depth(atd), .async_rx_depth(ard),
    .async_tx_full(atf), .async_rx_empty(are), .irq(irq)
  );

  bfrc_host bfrc_host_i (
    .clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [DATA_W-1:0] misc(logic [CODE_W-1:0] c);
    return {1'b0, c, 2'b00, txc, 7'h00, rxc};
  endfunction : misc

  function automatic logic [DATA_W-1:0] occ(logic [11:0] free, logic [11:0] fill);
    return {4'h0, free, 4'h0, fill};
  endfunction : occ

  // full and empty flags, then tx and rx depth outputs
  function automatic logic [DATA_W-1:0] fst(logic f, logic e, logic [9:0] t, logic [9:0] r);
    return {10'h000, f, e, t, r};
  endfunction : fst

  // alternate tx size only for classes up to five
  function automatic logic [CELL_W-1:0] exp_tx(int s, int c, logic [CELL_W-1:0] std);
    return (s == 1 && c <= 5) ? txc : std;
  endfunction : exp_tx

  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    bfrc_host_i.rd(a, d);
    chk(d, e);
  endtask : rchk

  // one-cycle strobes with their qualifying levels
  task automatic ev(input logic [7:0] s, input logic [9:0] l);
    @(posedge clk);
    stb <= s;
    lv  <= l;
    @(posedge clk);
    stb <= '0;
    lv  <= '0;
  endtask : ev

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    seed = 32'h088c;
    srst = 1'b1;
    stb = '0;
    lv = '0;
    tx_class = '0;
    std_tx_cell_size = '0;
    std_rx_cell_size = '0;
    txc = '0;
    rxc = '0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rchk(MISC_OFS, 32'h0);
    rchk(PTR_OFS, 32'h0);
    rchk(WIN_OFS, 32'h0);
    rchk(PTR_OFS, 32'h1);
    rchk(DEPTH_OFS, 32'h0000007d);
    rchk(OCC_OFS, 32'h0);
    chk(fst(atf, are, atd, ard), fst(1'b1, 1'b1, TXD_RST, RXD_RST));
    rchk(12'h300, 32'h0);
    bfrc_host_i.wr(MISC_OFS, 32'hffffffff);
    txc = 9'h1ff;
    rxc = 9'h1ff;
    rchk(MISC_OFS, misc(CODE_NONE));
    txc = 9'($random(seed));
    rxc = 9'($random(seed));
    bfrc_host_i.wr(MISC_OFS, misc(CODE_NONE));
    // window writes straddle the pointer wrap
    bfrc_host_i.wr(PTR_OFS, 32'h000007fe);
    for (int i = 0; i < 4; i++) begin
      ram[i] = $random(seed);
      bfrc_host_i.wr(WIN_OFS, ram[i]);
    end
    rchk(PTR_OFS, 32'h2);
    bfrc_host_i.wr(PTR_OFS, 32'h000007fe);
    for (int i = 0; i < 4; i++) rchk(WIN_OFS, ram[i]);
    bfrc_host_i.wr(DEPTH_OFS, 32'h00010001);
    rchk(DEPTH_OFS, 32'h00010001);
    chk(fst(atf, are, atd, ard), fst(1'b0, 1'b1, 10'h001, 10'h001));
    bfrc_host_i.wr(IRQ_MASK_OFS, 32'h1);
    rchk(OCC_OFS, occ(12'd4, 12'd0));
    repeat (5) ev(8'h01, 10'h000);
    rchk(MISC_OFS, misc(CODE_ATX_FULL));
    chk({31'h0, irq}, 32'h1);
    rchk(OCC_OFS, occ(12'd0, 12'd0));
    chk(fst(atf, are, atd, ard), fst(1'b1, 1'b1, 10'h001, 10'h001));
    ev(8'h02, 10'h000);
    repeat (5) ev(8'h04, 10'h000);
    rchk(OCC_OFS, occ(12'd1, 12'd4));
    chk(fst(atf, are, atd, ard), fst(1'b0, 1'b0, 10'h001, 10'h001));
    bfrc_host_i.wr(IRQ_STAT_OFS, 32'h3);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    repeat (5) ev(8'h08, 10'h000);
    rchk(MISC_OFS, misc(CODE_ARX_EMPTY));
    chk(fst(atf, are, atd, ard), fst(1'b0, 1'b1, 10'h001, 10'h001));
    ev(8'h04, 10'h000);
    ev(8'h08, 10'h001);
    rchk(MISC_OFS, misc(CODE_ARX_PAUSED));
    rchk(OCC_OFS, occ(12'd1, 12'd1));
    for (int k = 4; k <= 12; k++) begin
      ev(8'h01 << sidx[k], 10'h001 << (k - 3));
      rchk(MISC_OFS, misc(4'(k)));
    end
    // a legal pop must leave the last code alone
    ev(8'h40, 10'h000);
    rchk(MISC_OFS, misc(CODE_MTX_APP));
    for (int s = 0; s < 2; s++) begin
      bfrc_host_i.wr(CTRL_OFS, 32'(s) << ALT_SEL_BIT);
      for (int c = 0; c < 8; c++) begin
        stx = 9'($random(seed));
        srx = 9'($random(seed));
        @(posedge clk);
        tx_class <= 3'(c);
        std_tx_cell_size <= stx;
        std_rx_cell_size <= srx;
        @(posedge clk);
        @(negedge clk);
        chk({23'h0, eff_tx_cell_size}, {23'h0, exp_tx(s, c, stx)});
        chk({23'h0, eff_rx_cell_size}, {23'h0, (s == 1) ? rxc : srx});
      end
    end
    // second reset in mid-run
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rchk(MISC_OFS, 32'h0);
    rchk(PTR_OFS, 32'h0);
    rchk(OCC_OFS, 32'h0);
    rchk(DEPTH_OFS, 32'h0000007d);
    chk(fst(atf, are, atd, ard), fst(1'b1, 1'b1, TXD_RST, RXD_RST));
    wrap_up();
  end
endmodule : tb
